// [shared/sfs_pkg.sv]
package sfs_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int OFF_TIME_MS = 100;
    localparam int OFF_CYCLES = OFF_TIME_MS * (CLK_HZ / 1000);
    localparam int TMR_W = 24;
    localparam int N_OUT = 5;
    localparam int N_BUCK = 3;
    localparam logic [4:0] OC_RUN = 5'h10;

    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_OV_MASK = 8'h01;
    localparam logic [7:0] ADDR_UV_MASK = 8'h02;
    localparam logic [7:0] ADDR_OV_FLAG = 8'h03;
    localparam logic [7:0] ADDR_UV_FLAG = 8'h04;
    localparam logic [7:0] ADDR_OUT_FAULT = 8'h05;
    localparam logic [7:0] ADDR_OC = 8'h06;
    localparam logic [7:0] ADDR_OC_MASK = 8'h07;
    localparam logic [7:0] ADDR_OVW_MASK = 8'h08;
    localparam logic [7:0] ADDR_SHDN = 8'h09;
    localparam logic [7:0] ADDR_SCALE = 8'h0A;

    localparam int ST_SYS_LIVE = 0;
    localparam int ST_SYS_STAT = 1;
    localparam int ST_WARN_LIVE = 2;
    localparam int ST_WARN_STAT = 3;
    localparam int ST_OVW = 4;
    localparam int ST_OVSD = 5;
    localparam int SHDN_DIS_BIT = 0;
    localparam int OC_PEND_LSB = 4;
    localparam int SCALE_ACT_BIT = 7;

    localparam logic [4:0] OUT_MASK_RST = 5'h1F;
    localparam logic [2:0] OC_MASK_RST = 3'h7;
    localparam logic OVW_MASK_RST = 1'b1;
    localparam logic SHDN_DIS_RST = 1'b0;
    localparam logic [2:0] SCALE_RST = 3'h0;

    typedef enum logic [3:0] {
        SFS_RESET = 4'h1,
        SFS_START = 4'h2,
        SFS_ACTIVE = 4'h4,
        SFS_FAULT = 4'h8
    } sfs_state_e;
endpackage

// [hdl/sfs_supervisor.sv]
// Behaviour
// - Bus scaling entry honoured only while the factory scaling enable bit is 1.
// - Scaling active when the written request field is not 000, the enable bit is 1 and the state is active.
// - Bus enabled only above lockout; strap picks the 2.6V or 3.5V comparator.
// - Outputs stay off until the input rises above the monitor level.
// - Dropping below monitor level above lockout does not shut outputs.
// - Monitor comparison shown live on a low-active pin and a status bit.
// - Below monitor level raises a latched interrupt unless NVM mask; status read clears.
// - Warning level shown live on status bit and low-active pin.
// - Below warning level raises a latched interrupt unless masked; status read clears.
// - Each fault source except overvoltage warn has a live flag independent of its mask.
// - Mask gates fault bit except for overvoltage warn; any set fault bit pulls the interrupt low.
// - Fault bit clears only after condition gone and host read it.
// - Below lockout: reset state, outputs off, reset out low.
// - Above first overvoltage level: interrupt raised, outputs stay on.
// - Overvoltage warn status live when its mask is 0, latched when 1.
// - Above shutdown overvoltage: reset state, outputs off, bus still usable.
// - Falling below shutdown overvoltage restarts from sequence start.
// - Output fault shutdown only with both masks 0 and global disable 0.
// - Enabled output fault: all off 100ms, then sequence start again.
// - All fault masks reset masked; live output flags kept regardless.
// - Any output over/undervoltage drives reset out low.
// - Buck current at 80% over 17 switching cycles sets flag and unmasked interrupt.
`timescale 1ns/10ps
module sfs_supervisor #(
    parameter int OFF_CYC = sfs_pkg::OFF_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic analog_input_supply_lockout_lo_i,
    input wire logic analog_input_supply_lockout_hi_i,
    input wire logic system_monitor_level_i,
    input wire logic input_warning_level_i,
    input wire logic input_overvoltage_warn_level_i,
    input wire logic input_overvoltage_shutdown_level_i,
    input wire logic [sfs_pkg::N_OUT-1:0] out_ov_i,
    input wire logic [sfs_pkg::N_OUT-1:0] out_uv_i,
    input wire logic [sfs_pkg::N_BUCK-1:0] buck_oc80_i,
    input wire logic [sfs_pkg::N_BUCK-1:0] buck_sw_cycle_i,
    input wire logic lockout_level_select_i,
    input wire logic scaling_by_bus_enable_i,
    input wire logic system_monitor_level_irq_mask_i,
    input wire logic warn_irq_mask_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic interrupt_out_n_o,
    output logic system_reset_out_n_o,
    output logic outputs_on_o,
    output logic seq_start_o,
    output logic bus_enable_o,
    output logic system_monitor_level_pin_n_o,
    output logic warn_pin_n_o,
    output logic scaling_active_o
);
    import sfs_pkg::*;

    localparam int NS = 6 + 2 * N_OUT + 2 * N_BUCK;

    function automatic logic hit(input logic s, input logic [7:0] a, input logic [7:0] r);
        hit = s && (a == r);
    endfunction

    logic [NS-1:0] raw, s1, s2, s3, filt;
    logic level_reg;
    logic lk_ok, sys_above, warn_above, ovw_live, ovsd;
    logic [N_OUT-1:0] ov_live, uv_live;
    logic [N_BUCK-1:0] oc80, sw_cyc, sw_d, oc_flag;
    logic [N_OUT-1:0] ov_mask_reg, uv_mask_reg, out_pend_reg;
    logic [N_BUCK-1:0] oc_mask_reg, oc_pend_reg;
    logic ovw_mask_reg, shdn_dis_reg, ovw_lat_reg;
    logic sys_pend_reg, warn_pend_reg;
    logic [2:0] scale_reg;
    logic sd_fault, sys_set, warn_set;
    logic [TMR_W-1:0] tmr_reg;
    logic [7:0] rd_next;
    sfs_state_e st;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    assign raw = {buck_sw_cycle_i, buck_oc80_i, out_uv_i, out_ov_i,
                  input_overvoltage_shutdown_level_i, input_overvoltage_warn_level_i,
                  input_warning_level_i, system_monitor_level_i,
                  analog_input_supply_lockout_hi_i, analog_input_supply_lockout_lo_i};

    // Third stage only confirms; a change is taken once two stages agree
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            filt <= '0;
        end
        else
        begin
            s1 <= raw;
            s2 <= s1;
            s3 <= s2;
            filt <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
        end
    end

    a_sync_agree: assert property ($changed(filt) |-> $past(s2) == $past(s3))
        else $error("synchronised input changed without agreement");

    // Factory strap caught while reset is held
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            level_reg <= lockout_level_select_i;
    end

    assign lk_ok = level_reg ? filt[1] : filt[0];
    assign sys_above = filt[2];
    assign warn_above = filt[3];
    assign ovw_live = filt[4];
    assign ovsd = filt[5];
    assign ov_live = filt[6 +: N_OUT];
    assign uv_live = filt[6 + N_OUT +: N_OUT];
    assign oc80 = filt[6 + 2 * N_OUT +: N_BUCK];
    assign sw_cyc = filt[6 + 2 * N_OUT + N_BUCK +: N_BUCK];

    // Software-written configuration
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            ov_mask_reg <= OUT_MASK_RST;
            uv_mask_reg <= OUT_MASK_RST;
            oc_mask_reg <= OC_MASK_RST;
            ovw_mask_reg <= OVW_MASK_RST;
            shdn_dis_reg <= SHDN_DIS_RST;
            scale_reg <= SCALE_RST;
        end
        else if (reg_wr_i)
        begin
            if (reg_addr_i == ADDR_OV_MASK)
                ov_mask_reg <= reg_wdata_i[N_OUT-1:0];
            if (reg_addr_i == ADDR_UV_MASK)
                uv_mask_reg <= reg_wdata_i[N_OUT-1:0];
            if (reg_addr_i == ADDR_OC_MASK)
                oc_mask_reg <= reg_wdata_i[N_BUCK-1:0];
            if (reg_addr_i == ADDR_OVW_MASK)
                ovw_mask_reg <= reg_wdata_i[0];
            if (reg_addr_i == ADDR_SHDN)
                shdn_dis_reg <= reg_wdata_i[SHDN_DIS_BIT];
            if (reg_addr_i == ADDR_SCALE)
                scale_reg <= reg_wdata_i[2:0];
        end
    end

    // Run of switching cycles at 80% current, saturating just past the limit
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            sw_d <= '0;
        else
            sw_d <= sw_cyc;
    end

    genvar gi;
    generate
        for (gi = 0; gi < N_BUCK; gi++)
        begin : g_oc
            logic [4:0] run_reg;
            always_ff @(posedge clock_i)
            begin
                if (!rst_n_i || !oc80[gi])
                    run_reg <= '0;
                else if (sw_cyc[gi] && !sw_d[gi] && run_reg <= OC_RUN)
                    run_reg <= run_reg + 5'h01;
            end
            assign oc_flag[gi] = run_reg > OC_RUN;
        end
    endgenerate

    assign sys_set = !sys_above && !system_monitor_level_irq_mask_i;
    assign warn_set = !warn_above && !warn_irq_mask_i;

    // Sticky fault bits: a present condition re-sets in the same cycle as a read
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            sys_pend_reg <= 1'b0;
            warn_pend_reg <= 1'b0;
            ovw_lat_reg <= 1'b0;
            out_pend_reg <= '0;
            oc_pend_reg <= '0;
        end
        else
        begin
            sys_pend_reg <= sys_set | (sys_pend_reg & ~hit(reg_rd_i, reg_addr_i, ADDR_STATUS));
            warn_pend_reg <= warn_set | (warn_pend_reg & ~hit(reg_rd_i, reg_addr_i, ADDR_STATUS));
            ovw_lat_reg <= ovw_live | (ovw_lat_reg & ~hit(reg_rd_i, reg_addr_i, ADDR_STATUS));
            out_pend_reg <= ((ov_live & ~ov_mask_reg) | (uv_live & ~uv_mask_reg))
                | (out_pend_reg & {N_OUT{~hit(reg_rd_i, reg_addr_i, ADDR_OUT_FAULT)}});
            oc_pend_reg <= (oc_flag & ~oc_mask_reg)
                | (oc_pend_reg & {N_BUCK{~hit(reg_rd_i, reg_addr_i, ADDR_OC)}});
        end
    end

    a_sys_hold: assert property (sys_pend_reg && sys_set |=> sys_pend_reg)
        else $error("monitor fault bit cleared while condition present");
    a_ovw_latch: assert property (ovw_lat_reg && !ovw_live && !hit(reg_rd_i, reg_addr_i, ADDR_STATUS)
        |=> ovw_lat_reg)
        else $error("overvoltage warn latch dropped without read");
    a_oc_pend: assert property (oc_flag[0] && !oc_mask_reg[0] |=> oc_pend_reg[0] ##1 !interrupt_out_n_o)
        else $error("buck overcurrent did not raise interrupt");

    // An output fault shuts down only when both its masks are clear and the global disable is 0
    assign sd_fault = !shdn_dis_reg && |((ov_live | uv_live) & ~ov_mask_reg & ~uv_mask_reg);

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            st <= SFS_RESET;
        else if (!lk_ok)
            st <= SFS_RESET;
        else if (ovsd)
            st <= SFS_RESET;
        else
        begin
            unique case (st)
                SFS_RESET:
                    if (sys_above)
                        st <= SFS_START;
                SFS_START:
                    st <= SFS_ACTIVE;
                SFS_ACTIVE:
                    if (sd_fault)
                        st <= SFS_FAULT;
                SFS_FAULT:
                    if (tmr_reg == TMR_W'(OFF_CYC - 1))
                        st <= SFS_START;
                default:
                    st <= SFS_RESET;
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || st != SFS_FAULT)
            tmr_reg <= '0;
        else
            tmr_reg <= tmr_reg + TMR_W'(1);
    end

    sequence s_fault_entry;
        st == SFS_ACTIVE && sd_fault && lk_ok && !ovsd;
    endsequence

    sequence s_fault_done;
        st == SFS_FAULT && tmr_reg == TMR_W'(OFF_CYC - 1) && lk_ok && !ovsd;
    endsequence

    a_fault_off: assert property (s_fault_entry |=> st == SFS_FAULT ##1 !outputs_on_o)
        else $error("output fault did not shut outputs");
    a_fault_restart: assert property (s_fault_done |=> st == SFS_START ##1 seq_start_o)
        else $error("no restart after fault off time");
    a_lockout_off: assert property (!lk_ok |=> !bus_enable_o ##1 !outputs_on_o && !system_reset_out_n_o)
        else $error("outputs on below lockout");
    a_ovsd_reset: assert property (ovsd && lk_ok |=> st == SFS_RESET && bus_enable_o)
        else $error("shutdown overvoltage not handled");
    a_wait_monitor: assert property (st == SFS_RESET && !sys_above |=> st == SFS_RESET)
        else $error("started below monitor level");
    a_monitor_keep: assert property (st == SFS_ACTIVE && !sys_above && lk_ok && !ovsd && !sd_fault
        |=> st == SFS_ACTIVE)
        else $error("outputs shut on monitor drop");

    always_comb
    begin
        rd_next = 8'h00;
        unique case (reg_addr_i)
            ADDR_STATUS:
            begin
                rd_next[ST_SYS_LIVE] = sys_above;
                rd_next[ST_SYS_STAT] = sys_pend_reg;
                rd_next[ST_WARN_LIVE] = warn_above;
                rd_next[ST_WARN_STAT] = warn_pend_reg;
                rd_next[ST_OVW] = ovw_mask_reg ? ovw_lat_reg : ovw_live;
                rd_next[ST_OVSD] = ovsd;
            end
            ADDR_OV_MASK: rd_next[N_OUT-1:0] = ov_mask_reg;
            ADDR_UV_MASK: rd_next[N_OUT-1:0] = uv_mask_reg;
            ADDR_OV_FLAG: rd_next[N_OUT-1:0] = ov_live;
            ADDR_UV_FLAG: rd_next[N_OUT-1:0] = uv_live;
            ADDR_OUT_FAULT: rd_next[N_OUT-1:0] = out_pend_reg;
            ADDR_OC:
            begin
                rd_next[N_BUCK-1:0] = oc_flag;
                rd_next[OC_PEND_LSB +: N_BUCK] = oc_pend_reg;
            end
            ADDR_OC_MASK: rd_next[N_BUCK-1:0] = oc_mask_reg;
            ADDR_OVW_MASK: rd_next[0] = ovw_mask_reg;
            ADDR_SHDN: rd_next[SHDN_DIS_BIT] = shdn_dis_reg;
            ADDR_SCALE:
            begin
                rd_next[2:0] = scale_reg;
                rd_next[SCALE_ACT_BIT] = scaling_active_o;
            end
            default: rd_next = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            reg_rdata_o <= 8'h00;
            interrupt_out_n_o <= 1'b1;
            system_reset_out_n_o <= 1'b0;
            outputs_on_o <= 1'b0;
            seq_start_o <= 1'b0;
            bus_enable_o <= 1'b0;
            system_monitor_level_pin_n_o <= 1'b0;
            warn_pin_n_o <= 1'b0;
            scaling_active_o <= 1'b0;
        end
        else
        begin
            if (reg_rd_i)
                reg_rdata_o <= rd_next;
            interrupt_out_n_o <= ~(sys_pend_reg | warn_pend_reg | ovw_lat_reg
                | (|out_pend_reg) | (|oc_pend_reg));
            system_reset_out_n_o <= (st == SFS_ACTIVE) && !(|(ov_live | uv_live));
            outputs_on_o <= st == SFS_ACTIVE;
            seq_start_o <= st == SFS_START;
            bus_enable_o <= lk_ok;
            system_monitor_level_pin_n_o <= sys_above;
            warn_pin_n_o <= warn_above;
            scaling_active_o <= scaling_by_bus_enable_i && scale_reg != 3'h0 && st == SFS_ACTIVE;
        end
    end

    a_irq_sys: assert property (sys_pend_reg |=> !interrupt_out_n_o)
        else $error("set fault bit did not pull interrupt low");
    a_reset_fault: assert property (|(ov_live | uv_live) |=> !system_reset_out_n_o)
        else $error("reset out high during output fault");
    a_scale_gate: assert property (scaling_active_o |-> $past(scaling_by_bus_enable_i)
        && $past(scale_reg) != 3'h0)
        else $error("scaling active without enable or request");
endmodule

// [sim/sfs_host.sv]
`timescale 1ns/10ps
module sfs_host (
    input wire logic clock_i,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i
);
    initial
    begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h5A;
        reg_wdata_o = 8'hA5;
    end

    // Released lines are inverted so a stale address never looks valid
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge clock_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = wr;
        reg_rd_o = !wr;
        @(negedge clock_i);
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
        @(negedge clock_i);
        q = reg_rdata_i;
    endtask
endmodule

// [sim/sfs_supervisor_test.sv]
`timescale 1ns/10ps
module sfs_supervisor_test;
    import sfs_pkg::*;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic lo = 1'b0, hi = 1'b0, mon = 1'b0, warn = 1'b0, ovw = 1'b0, ovsd = 1'b0, dvs_en = 1'b0;
    logic strap = 1'b0, mon_mask = 1'b0, warn_mask = 1'b0;
    logic [N_OUT-1:0] ov = '0, uv = '0;
    logic [N_BUCK-1:0] oc80 = '0, swc = '0;
    logic wr, rd, irq_n, rst_out_n, on, seq, bus_en, mon_n, warn_n, scal;
    logic [7:0] addr, wdata, rdata;
    logic seen_seq = 1'b0;
    int fail_count = 0;
    int samples_checked = 0;

    initial
    begin
        forever #5 clock_i = ~clock_i;
    end

    always @(posedge clock_i)
    begin
        if (seq === 1'b1)
            seen_seq = 1'b1;
    end

    sfs_host host (.clock_i(clock_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wdata),
        .reg_rdata_i(rdata));

    // Short off time keeps the restart visible within a short run
    sfs_supervisor #(.OFF_CYC(20)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .analog_input_supply_lockout_lo_i(lo), .analog_input_supply_lockout_hi_i(hi),
        .system_monitor_level_i(mon), .input_warning_level_i(warn), .input_overvoltage_warn_level_i(ovw),
        .input_overvoltage_shutdown_level_i(ovsd), .out_ov_i(ov), .out_uv_i(uv), .buck_oc80_i(oc80),
        .buck_sw_cycle_i(swc), .lockout_level_select_i(strap), .scaling_by_bus_enable_i(dvs_en),
        .system_monitor_level_irq_mask_i(mon_mask), .warn_irq_mask_i(warn_mask), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .interrupt_out_n_o(irq_n),
        .system_reset_out_n_o(rst_out_n), .outputs_on_o(on), .seq_start_o(seq), .bus_enable_o(bus_en),
        .system_monitor_level_pin_n_o(mon_n), .warn_pin_n_o(warn_n), .scaling_active_o(scal));

    task automatic tally_and_finish();
        if (fail_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        host.xfer(1'b0, a, 8'h00, q);
        check(q, exp);
    endtask

    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.xfer(1'b1, a, d, q);
    endtask

    task automatic wait_on(input logic want);
        int n;
        n = 0;
        while (on !== want && n < 100)
        begin
            @(negedge clock_i);
            n++;
        end
        if (on !== want)
        begin
            check(on, want);
            tally_and_finish();
        end
    endtask

    task automatic t_startup();
        lo = 1'b1;
        cyc(10);
        check(bus_en, 1'b1);
        check(on, 1'b0);
        rdc(ADDR_OV_MASK, 8'h1F);
        rdc(ADDR_UV_MASK, 8'h1F);
        rdc(ADDR_OC_MASK, 8'h07);
        rdc(ADDR_OVW_MASK, 8'h01);
        rdc(ADDR_SHDN, 8'h00);
        rdc(8'h3C, 8'h00);
        mon = 1'b1;
        warn = 1'b1;
        wait_on(1'b1);
        check(seen_seq, 1'b1);
        check(rst_out_n, 1'b1);
        rdc(ADDR_STATUS, 8'h0F);
        cyc(3);
        check(irq_n, 1'b1);
    endtask

    task automatic t_system_monitor_level();
        mon = 1'b0;
        warn = 1'b0;
        cyc(8);
        check(on, 1'b1);
        check(mon_n, 1'b0);
        check(warn_n, 1'b0);
        check(irq_n, 1'b0);
        rdc(ADDR_STATUS, 8'h0A);
        cyc(3);
        check(irq_n, 1'b0);
        mon = 1'b1;
        warn = 1'b1;
        cyc(8);
        check(irq_n, 1'b0);
        rdc(ADDR_STATUS, 8'h0F);
        cyc(3);
        check(irq_n, 1'b1);
    endtask

    task automatic t_ovw();
        ovw = 1'b1;
        cyc(8);
        check(irq_n, 1'b0);
        check(on, 1'b1);
        ovw = 1'b0;
        cyc(8);
        rdc(ADDR_STATUS, 8'h15);
        cyc(3);
        check(irq_n, 1'b1);
        wrr(ADDR_OVW_MASK, 8'h00);
        ovw = 1'b1;
        cyc(8);
        rdc(ADDR_STATUS, 8'h15);
        ovw = 1'b0;
        cyc(8);
        rdc(ADDR_STATUS, 8'h05);
        cyc(3);
        check(irq_n, 1'b1);
    endtask

    task automatic t_outfault();
        uv[0] = 1'b1;
        cyc(8);
        check(on, 1'b1);
        check(rst_out_n, 1'b0);
        rdc(ADDR_UV_FLAG, 8'h01);
        uv[0] = 1'b0;
        wrr(ADDR_UV_MASK, 8'h1E);
        wrr(ADDR_OV_MASK, 8'h1E);
        wrr(ADDR_SHDN, 8'h01);
        ov[0] = 1'b1;
        cyc(8);
        check(on, 1'b1);
        ov[0] = 1'b0;
        // Let the synchronised flag drop before re-enabling shutdown
        cyc(8);
        wrr(ADDR_SHDN, 8'h00);
        seen_seq = 1'b0;
        uv[0] = 1'b1;
        wait_on(1'b0);
        uv[0] = 1'b0;
        cyc(15);
        check(on, 1'b0);
        wait_on(1'b1);
        check(seen_seq, 1'b1);
        rdc(ADDR_OUT_FAULT, 8'h01);
        rdc(ADDR_OUT_FAULT, 8'h00);
        cyc(3);
        check(irq_n, 1'b1);
    endtask

    task automatic t_ovsd();
        ovsd = 1'b1;
        wait_on(1'b0);
        check(bus_en, 1'b1);
        check(rst_out_n, 1'b0);
        seen_seq = 1'b0;
        ovsd = 1'b0;
        wait_on(1'b1);
        check(seen_seq, 1'b1);
    endtask

    task automatic t_scale();
        wrr(ADDR_SCALE, 8'h03);
        cyc(2);
        check(scal, 1'b0);
        dvs_en = 1'b1;
        wrr(ADDR_SCALE, 8'h05);
        cyc(2);
        check(scal, 1'b1);
        rdc(ADDR_SCALE, 8'h85);
        wrr(ADDR_SCALE, 8'h00);
        cyc(2);
        check(scal, 1'b0);
    endtask

    task automatic t_oc();
        wrr(ADDR_OC_MASK, 8'h06);
        oc80[0] = 1'b1;
        cyc(6);
        repeat (16)
        begin
            swc[0] = 1'b1;
            cyc(2);
            swc[0] = 1'b0;
            cyc(2);
        end
        cyc(6);
        check(irq_n, 1'b1);
        rdc(ADDR_OC, 8'h00);
        swc[0] = 1'b1;
        cyc(2);
        swc[0] = 1'b0;
        cyc(6);
        check(irq_n, 1'b0);
        rdc(ADDR_OC, 8'h11);
        oc80[0] = 1'b0;
        cyc(6);
        rdc(ADDR_OC, 8'h10);
        cyc(3);
        check(irq_n, 1'b1);
    endtask

    task automatic t_lockout();
        lo = 1'b0;
        wait_on(1'b0);
        cyc(2);
        check(rst_out_n, 1'b0);
        check(bus_en, 1'b0);
    endtask

    // Strap is only taken while reset is held, so a second reset is needed
    task automatic t_strap();
        strap = 1'b1;
        mon_mask = 1'b1;
        warn_mask = 1'b1;
        mon = 1'b0;
        warn = 1'b0;
        rst_n_i = 1'b0;
        cyc(4);
        check(irq_n, 1'b1);
        rst_n_i = 1'b1;
        lo = 1'b1;
        cyc(10);
        check(bus_en, 1'b0);
        hi = 1'b1;
        cyc(8);
        check(bus_en, 1'b1);
        check(irq_n, 1'b1);
        check(on, 1'b0);
        rdc(ADDR_STATUS, 8'h00);
    endtask

    initial
    begin
        cyc(10);
        check(irq_n, 1'b1);
        check(rst_out_n, 1'b0);
        check(on, 1'b0);
        rst_n_i = 1'b1;
        t_startup();
        t_system_monitor_level();
        t_ovw();
        t_outfault();
        t_ovsd();
        t_scale();
        t_oc();
        t_lockout();
        t_strap();
        tally_and_finish();
    end
endmodule
